// ### hdl/config_word_consts.svh
// offsets, field positions, reset values and timing counts of the
// configuration word and start-up holds; included by its bare name
`ifndef CONFIG_WORD_CONSTS_SVH
`define CONFIG_WORD_CONSTS_SVH

`define CFG_WORD_ADDR      14'h2007
`define CFG_SPACE_LO       14'h2000
`define CFG_SPACE_HI       14'h3FFF
`define CFG_WORD_RESET     14'h3FFF
`define CFG_UNIMPL_BIT     7
`define CFG_POWERUP_DELAY_TIMER_DIS_BIT   3
`define CFG_WDT_EN_BIT     2
`define CFG_CP_HI_MSB      13
`define CFG_CP_HI_LSB      8
`define CFG_CP_LO_MSB      5
`define CFG_CP_LO_LSB      4
`define CFG_OSC_MSB        1
`define CFG_OSC_LSB        0
`define OSC_MODE_LP        2'h0
`define OSC_MODE_XT        2'h1
`define OSC_MODE_HS        2'h2
`define OSC_MODE_RC        2'h3
`define CLK_MHZ            250
`define POWERUP_DELAY_TIMER_MS            72
`define POWERUP_DELAY_TIMER_CYCLES        (`POWERUP_DELAY_TIMER_MS * `CLK_MHZ * 1000)
`define OST_OSC_CYCLES     11'h400
`define WDT_RC_TICKS       16'h0FFF

`endif

// ### hdl/config_word_pkg.sv
// types of the configuration loader and start-up control
// assumes config_word_consts.svh for all numeric values
package config_word_pkg;

  typedef enum logic [1:0] {
    ST_POWERUP_DELAY_TIMER,
    ST_OST,
    ST_RUN,
    ST_SLEEP
  } startup_state_t;

  typedef enum logic [1:0] {
    WAKE_NONE,
    WAKE_EXTERNAL,
    WAKE_WATCHDOG,
    WAKE_INTERRUPT
  } wake_cause_t;

  typedef struct packed {
    logic        progMode;
    logic        rd;
    logic        wr;
    logic [13:0] addr;
    logic [13:0] wdata;
  } prog_req_t;

  typedef struct packed {
    logic [1:0] oscSelect;
    logic       watchdogEnable;
    logic       powerupDelayEnable;
    logic [5:0] codeProtectHi;
    logic [1:0] codeProtectLo;
  } cfg_decoded_t;

endpackage

// ### hdl/config_word_startup_control.sv
// configuration word store, decode and start-up/sleep hold sequencing
// assumes a programming host on the prog port, async pins on the
// oscillator input, watchdog rc oscillator and external reset
`timescale 1ns/1ps
`include "config_word_consts.svh"

// Summary of operation
// - Programmed configuration bits read 0, unprogrammed bits read 1.
// - Configuration word lives at address 2007h, outside user memory.
// - Space 2000h to 3FFFh is reachable only in programming mode.
// - Two oscillator-select bits choose one of four oscillator modes.
// - Watchdog enabled by a bit, clocked by its own rc oscillator.
// - Power-up delay holds reset a nominal 72 ms, at power-up only.
// - Oscillator start-up timer holds reset until the crystal is stable.
// - Sleep ends on external reset, watchdog wake-up or interrupt.
// - Crystal modes also accept an external clock on the input pin.
// - Power-up delay disabled when its bit is set, enabled when clear.
// - Start-up timer counts 1024 input cycles after the power-up delay.
// - Start-up delay only in crystal modes, on power-up or sleep wake.
module config_word_startup_control #(
  parameter int POWERUP_DELAY_TIMER_CYCLES = `POWERUP_DELAY_TIMER_CYCLES
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  // programming port
  input  wire config_word_pkg::prog_req_t    progReq,
  output logic [13:0]                        progRdata,
  // pins
  input  wire logic                          oscInputPin,
  input  wire logic                          watchdogRcClk,
  input  wire logic                          extResetPin_n,
  // core side
  input  wire logic                          sleepRequest,
  input  wire logic                          wakeInterrupt,
  input  wire logic                          watchdogClear,
  // decoded settings and status
  output config_word_pkg::cfg_decoded_t      cfgDecoded,
  output logic                               deviceHoldReset,
  output logic                               sleeping,
  output logic                               watchdogResetPulse,
  output config_word_pkg::wake_cause_t       wakeCause
);
  import config_word_pkg::*;

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  logic [13:0]    cfgWord_q;
  logic [13:0]    progRdata_q;
  logic [2:0]     sync1_q;
  logic [2:0]     sync2_q;
  logic [2:0]     sync3_q;
  startup_state_t state_q;
  startup_state_t state_d;
  logic [24:0]    pwrtCount_q;
  logic [10:0]    ostCount_q;
  logic [15:0]    wdtCount_q;
  wake_cause_t    wakeCause_q;
  logic           wdtReset_q;

  // pin synchronisers: oscillator input, watchdog rc clock, external reset
  wire [2:0] pinsAsync = {extResetPin_n, watchdogRcClk, oscInputPin};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
          sync3_q[gi] <= 1'b1;
        end
        else
        begin
          sync1_q[gi] <= pinsAsync[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
        end
      end
    end
  endgenerate

  wire oscRise   = sync2_q[0] & ~sync3_q[0];
  wire wdtRise   = sync2_q[1] & ~sync3_q[1];
  wire extResetN = sync2_q[2];

  // programming access decode
  wire inTestSpace = progReq.progMode &&
                     progReq.addr >= `CFG_SPACE_LO &&
                     progReq.addr <= `CFG_SPACE_HI;
  wire cfgHit      = inTestSpace && progReq.addr == `CFG_WORD_ADDR;
  wire cfgWrite    = cfgHit && progReq.wr;
  wire [13:0] cfgReadback = cfgWord_q | (14'h1 << `CFG_UNIMPL_BIT);
  wire [13:0] rdata_d = (cfgHit && progReq.rd) ? cfgReadback : 14'h0;

  // eprom cells: programming can only pull a bit to 0
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      cfgWord_q <= `CFG_WORD_RESET;
    else if (cfgWrite)
      cfgWord_q <= cfgWord_q & progReq.wdata;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      progRdata_q <= 14'h0;
    else
      progRdata_q <= rdata_d;
  end

  assign progRdata = progRdata_q;

  // field decode
  assign cfgDecoded.oscSelect = cfgWord_q[`CFG_OSC_MSB:`CFG_OSC_LSB];
  assign cfgDecoded.watchdogEnable = cfgWord_q[`CFG_WDT_EN_BIT];
  assign cfgDecoded.powerupDelayEnable =
    ~cfgWord_q[`CFG_POWERUP_DELAY_TIMER_DIS_BIT];
  assign cfgDecoded.codeProtectHi = cfgWord_q[`CFG_CP_HI_MSB:`CFG_CP_HI_LSB];
  assign cfgDecoded.codeProtectLo = cfgWord_q[`CFG_CP_LO_MSB:`CFG_CP_LO_LSB];

  // rc mode has no start-up delay; crystal modes or external clock do
  wire crystalMode = cfgDecoded.oscSelect != `OSC_MODE_RC;
  wire pwrtDone    = pwrtCount_q == 25'(POWERUP_DELAY_TIMER_CYCLES - 1);
  wire ostDone     = ostCount_q == `OST_OSC_CYCLES;
  wire wdtTimeout  = cfgDecoded.watchdogEnable && wdtRise &&
                     wdtCount_q == `WDT_RC_TICKS;
  wire wakeEvent   = !extResetN || wdtTimeout || wakeInterrupt;
  startup_state_t wakeTarget;
  assign wakeTarget = crystalMode ? ST_OST : ST_RUN;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_POWERUP_DELAY_TIMER:  if (!cfgDecoded.powerupDelayEnable || pwrtDone)
                  state_d = wakeTarget;
      ST_OST:   if (ostDone)
                  state_d = ST_RUN;
      ST_RUN:   if (sleepRequest && extResetN)
                  state_d = ST_SLEEP;
      ST_SLEEP: if (wakeEvent)
                  state_d = wakeTarget;
      default:  state_d = ST_POWERUP_DELAY_TIMER;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= ST_POWERUP_DELAY_TIMER;
    else
      state_q <= state_d;
  end

  // power-up delay counts only once, from power-on
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pwrtCount_q <= 25'h0;
    else if (state_q == ST_POWERUP_DELAY_TIMER && !pwrtDone)
      pwrtCount_q <= pwrtCount_q + 25'h1;
  end

  // start-up timer counts rising edges of the oscillator input pin
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      ostCount_q <= 11'h0;
    else if (state_q != ST_OST)
      ostCount_q <= 11'h0;
    else if (oscRise && !ostDone)
      ostCount_q <= ostCount_q + 11'h1;
  end

  // watchdog counts its own rc oscillator, cleared on sleep entry
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      wdtCount_q <= 16'h0;
    else if (!cfgDecoded.watchdogEnable || watchdogClear || wdtTimeout ||
             state_d == ST_SLEEP && state_q == ST_RUN)
      wdtCount_q <= 16'h0;
    else if (wdtRise)
      wdtCount_q <= wdtCount_q + 16'h1;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wakeCause_q <= WAKE_NONE;
      wdtReset_q  <= 1'b0;
    end
    else
    begin
      wdtReset_q <= wdtTimeout && state_q == ST_RUN;
      if (state_q == ST_SLEEP && wakeEvent)
        wakeCause_q <= !extResetN ? WAKE_EXTERNAL :
                       wdtTimeout ? WAKE_WATCHDOG : WAKE_INTERRUPT;
      else if (state_d == ST_SLEEP && state_q == ST_RUN)
        wakeCause_q <= WAKE_NONE;
    end
  end

  assign deviceHoldReset    = state_q != ST_RUN || !extResetN;
  assign sleeping           = state_q == ST_SLEEP;
  assign watchdogResetPulse = wdtReset_q;
  assign wakeCause          = wakeCause_q;

  // checks
  a_program_clears: assert property (
    cfgWrite |=> (cfgWord_q & ~$past(progReq.wdata)) == 14'h0)
    else $error("programmed bit did not read back as zero");
  a_cfg_only_addr: assert property (
    $changed(cfgWord_q) |-> $past(cfgWrite))
    else $error("config word changed without a write to its address");
  a_prog_mode_only: assert property (
    !progReq.progMode ##1 1'b1 |-> progRdata == 14'h0)
    else $error("config space read outside programming mode");
  a_ost_crystal_only: assert property (
    state_q != ST_OST && state_d == ST_OST |-> crystalMode)
    else $error("start-up delay entered in rc mode");
  a_wdt_disabled: assert property (
    !cfgDecoded.watchdogEnable |=> wdtCount_q == 16'h0 && !wdtReset_q)
    else $error("watchdog ran while disabled");
  a_powerup_delay_timer_exact: assert property (
    state_q == ST_POWERUP_DELAY_TIMER && cfgDecoded.powerupDelayEnable && !pwrtDone
    |=> state_q == ST_POWERUP_DELAY_TIMER)
    else $error("power-up delay ended early");
  a_powerup_delay_timer_disable: assert property (
    state_q == ST_POWERUP_DELAY_TIMER && !cfgDecoded.powerupDelayEnable
    |=> state_q != ST_POWERUP_DELAY_TIMER)
    else $error("disabled power-up delay still held reset");
  a_ost_holds: assert property (
    state_q == ST_OST |-> deviceHoldReset)
    else $error("reset released during start-up delay");
  a_ost_count: assert property (
    state_q == ST_OST ##1 state_q == ST_RUN |-> $past(ostCount_q) == 11'h400)
    else $error("start-up delay left before 1024 input cycles");
  a_wake_sleep: assert property (
    state_q == ST_SLEEP && wakeInterrupt |=> !sleeping ##0
    wakeCause == WAKE_INTERRUPT || wakeCause == WAKE_EXTERNAL ||
    wakeCause == WAKE_WATCHDOG)
    else $error("interrupt did not wake from sleep");

  c_power_up_run: cover property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_OST ##1 state_q == ST_RUN);
  c_sleep_wdt_wake: cover property (@(posedge mclk) disable iff (!reset_n)
    sleeping ##1 wakeCause == WAKE_WATCHDOG);
  c_cfg_program: cover property (@(posedge mclk) disable iff (!reset_n)
    cfgWrite ##1 progReq.rd && cfgHit);
endmodule

// ### tb/osc_source_model.sv
// external clock source standing in for the crystal at the input pin
// assumes the bench enables it only while a start-up count is wanted
`timescale 1ns/1ps
module osc_source_model #(
  parameter realtime HALF = 10.3
) (
  // control
  input  wire logic enable,
  // pin
  output logic      oscOut
);
  // stands low while disabled, free of any mclk phase relation
  initial
  begin
    oscOut = 1'b0;
    forever
    begin
      #(HALF);
      if (enable)
        oscOut = ~oscOut;
      else
        oscOut = 1'b0;
    end
  end
endmodule

// ### tb/config_word_startup_control_test.sv
// bench for the configuration word loader and start-up hold control
// assumes the design files compiled first and a 250 MHz mclk
`timescale 1ns/1ps
module config_word_startup_control_test;
  import config_word_pkg::*;
  logic         mclk;
  logic         reset_n;
  prog_req_t    progReq;
  logic [13:0]  progRdata;
  logic         oscEn;
  logic         oscInputPin;
  logic         watchdogRcClk;
  logic         extResetPin_n;
  logic         sleepRequest;
  logic         wakeInterrupt;
  logic         watchdogClear;
  cfg_decoded_t cfgDecoded;
  logic         deviceHoldReset;
  logic         sleeping;
  logic         watchdogResetPulse;
  wake_cause_t  wakeCause;
  int           n_mismatch;
  int           cmp_count;
  int           oscEdges;
  int           wdPulses;

  config_word_startup_control #(.POWERUP_DELAY_TIMER_CYCLES(20)) uut (
    .mclk(mclk), .reset_n(reset_n), .progReq(progReq),
    .progRdata(progRdata), .oscInputPin(oscInputPin),
    .watchdogRcClk(watchdogRcClk), .extResetPin_n(extResetPin_n),
    .sleepRequest(sleepRequest), .wakeInterrupt(wakeInterrupt),
    .watchdogClear(watchdogClear), .cfgDecoded(cfgDecoded),
    .deviceHoldReset(deviceHoldReset), .sleeping(sleeping),
    .watchdogResetPulse(watchdogResetPulse), .wakeCause(wakeCause));
  osc_source_model osc (.enable(oscEn), .oscOut(oscInputPin));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge oscInputPin) oscEdges++;
  always @(posedge mclk) if (watchdogResetPulse === 1'b1) wdPulses++;

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [13:0] seen, logic [13:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request set after one edge, taken at the next; read data registered
  // at that taking edge stands only until the following edge
  task automatic access(logic m, logic r, logic w, logic [13:0] a,
                        logic [13:0] d);
    @(posedge mclk);
    progReq <= '{m, r, w, a, d};
    @(posedge mclk);
    progReq <= '{1'b0, 1'b0, 1'b0, 14'h0000, 14'h0000};
    #1;
  endtask

  task automatic rdchk(logic m, logic [13:0] a, logic [13:0] exp);
    access(m, 1'b1, 1'b0, a, 14'h0000);
    chk("progRdata", progRdata, exp);
  endtask

  task automatic pulse(int s);
    @(posedge mclk);
    if (s == 0)
      sleepRequest <= 1'b1;
    else
      wakeInterrupt <= 1'b1;
    @(posedge mclk);
    sleepRequest <= 1'b0;
    wakeInterrupt <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic rc_edges(int n);
    repeat (n)
    begin
      @(posedge mclk);
      watchdogRcClk <= 1'b1;
      repeat (3) @(posedge mclk);
      watchdogRcClk <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask

  task automatic wait_run(int bound);
    int n;
    n = 0;
    while (deviceHoldReset !== 1'b0 && n < bound)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= bound)
    begin
      n_mismatch++;
      $display("[FAIL] deviceHoldReset expected 0 seen %b", deviceHoldReset);
      tally_and_finish();
    end
  endtask

  task automatic do_reset();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
  endtask

  initial
  begin
    reset_n = 1'b0;
    progReq = '0;
    oscEn = 1'b0;
    watchdogRcClk = 1'b0;
    extResetPin_n = 1'b1;
    sleepRequest = 1'b0;
    wakeInterrupt = 1'b0;
    watchdogClear = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    oscEdges = 0;
    wdPulses = 0;
    do_reset();
    wait_run(10);
    chk("cfgDecoded", {2'b00, cfgDecoded}, 14'h0EFF);
    rdchk(1'b1, 14'h2007, 14'h3FFF);
    rdchk(1'b1, 14'h2000, 14'h0000);
    rdchk(1'b1, 14'h3FFF, 14'h0000);
    rdchk(1'b0, 14'h2007, 14'h0000);
    access(1'b0, 1'b0, 1'b1, 14'h2007, 14'h0000);
    rdchk(1'b1, 14'h2007, 14'h3FFF);
    $display("test config space done");
    @(posedge mclk);
    watchdogClear <= 1'b1;
    @(posedge mclk);
    watchdogClear <= 1'b0;
    rc_edges(4095);
    #1;
    chk("wdPulses", 14'(wdPulses), 14'h0000);
    rc_edges(1);
    repeat (6) @(posedge mclk);
    #1;
    chk("wdPulses", 14'(wdPulses), 14'h0001);
    $display("test watchdog done");
    access(1'b1, 1'b0, 1'b1, 14'h2007, 14'h3F71);
    rdchk(1'b1, 14'h2007, 14'h3FF1);
    chk("cfgDecoded", {2'b00, cfgDecoded}, 14'h05FF);
    pulse(0);
    chk("sleeping", {13'h0, sleeping}, 14'h0001);
    pulse(1);
    chk("wakeCause", {12'h0, wakeCause}, 14'h0003);
    repeat (50) @(posedge mclk);
    chk("deviceHoldReset", {13'h0, deviceHoldReset}, 14'h0001);
    oscEdges = 0;
    oscEn <= 1'b1;
    wait_run(8000);
    chk("ostEdges", {13'h0, (oscEdges >= 1024 && oscEdges <= 1028)},
        14'h0001);
    $display("test interrupt wake done");
    access(1'b1, 1'b0, 1'b1, 14'h2007, 14'h3F70);
    chk("cfgDecoded", {2'b00, cfgDecoded}, 14'h01FF);
    pulse(0);
    @(posedge mclk);
    extResetPin_n <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    chk("wakeCause", {12'h0, wakeCause}, 14'h0001);
    chk("deviceHoldReset", {13'h0, deviceHoldReset}, 14'h0001);
    @(posedge mclk);
    extResetPin_n <= 1'b1;
    wait_run(8000);
    $display("test external wake done");
    @(posedge mclk);
    oscEn <= 1'b0;
    do_reset();
    wait_run(10);
    pulse(0);
    pulse(1);
    wait_run(10);
    access(1'b1, 1'b0, 1'b1, 14'h2007, 14'h3FFE);
    chk("cfgDecoded", {2'b00, cfgDecoded}, 14'h0AFF);
    $display("test rc wake done");
    tally_and_finish();
  end
endmodule
